// >>> src/sscp_defs.svh
// Constants of the synchronous SRAM control port
`ifndef SSCP_DEFS_SVH
`define SSCP_DEFS_SVH

// ==========================================================
// Geometry
`define SSCP_ADDR_W 18
`define SSCP_BURST_W 2
`define SSCP_ADDR_HI_W 16
`define SSCP_DEPTH 262144
`define SSCP_LANES 4
`define SSCP_LANE_W 9
`define SSCP_DATA_W 36

// ==========================================================
// Lane masks and counter step
`define SSCP_LANES_ALL 4'hf
`define SSCP_LANES_NONE 4'h0
`define SSCP_BURST_STEP 2'h1
`define SSCP_BURST_RST 2'h0

`endif

// >>> src/sscp_pkg.sv
// Types of the synchronous SRAM control port
`include "sscp_defs.svh"

package sscp_pkg;
  // ==========================================================
  // Types
  typedef enum logic {
    SSCP_IDLE,
    SSCP_ACTIVE
  } sscp_state_e;

  typedef logic [`SSCP_LANES-1:0] sscp_lane_mask_t;
  typedef logic [`SSCP_ADDR_HI_W-1:0] sscp_addr_hi_t;
endpackage

// >>> src/sscp_burst_ctr.sv
// Two-bit burst address counter
`timescale 1ns/10ps
`include "sscp_defs.svh"

module sscp_burst_ctr (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic [`SSCP_BURST_W-1:0] seed_i,
  output logic [`SSCP_BURST_W-1:0] count_o
);

  // ==========================================================
  // Counter
  // Two bits only, so a step past the top wraps inside the group
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_o <= `SSCP_BURST_RST;
    end else if (load_i) begin
      count_o <= seed_i;
    end else if (step_i) begin
      count_o <= `SSCP_BURST_W'(count_o + `SSCP_BURST_STEP);
    end
  end

  // ==========================================================
  // Checks
  AST_CTR_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !load_i && !step_i |=> $stable(count_o))
    else $error("burst counter moved without a load or a step");

endmodule // sscp_burst_ctr

// >>> src/sscp_top.sv
// Control front end and array of the pipelined synchronous burst SRAM
`timescale 1ns/10ps
`include "sscp_defs.svh"

// Summary of operation
// - All synchronous inputs are taken only on the rising clock edge.
// - Address register indexes all 256K word locations.
// - Address captured when a strobe is low and all selects are active.
// - Captured low two address bits load the two-bit burst counter.
// - Advance low during a burst steps the counter at the clock edge.
// - Byte-lane selects write their lanes only when qualified by the lane qualifier.
// - Qualifier high means no lane is written unless global write is low.
// - Global write low writes all lanes, ignoring selects and qualifier.
// - First select is active low, sampled, part of selection.
// - Processor strobe ignored whenever the first select is high.
// - Second select is active high, sampled, part of selection.
// - Third select active low; treated as always active when absent.
// - Output enable is asynchronous, active low, drives the data pins.
// - Output enable high releases the data pins for write data.
// - First clock of a read after deselect keeps the outputs undriven.
// - When both strobes are low and the first select is low, only the processor strobe counts.
// - Driven data is the word addressed at the previous clock edge.
// - Write data is captured into a data register at the clock edge.

module sscp_top
  import sscp_pkg::*;
#(
  parameter bit SELECT_THIRD_PRESENT = 1'b1
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [`SSCP_ADDR_W-1:0] ADDR_I,
  input wire logic PROC_ADDR_STROBE_N_I,
  input wire logic CTRL_ADDR_STROBE_N_I,
  input wire logic SELECT_PRIMARY_N_I,
  input wire logic SELECT_EXPAND_HIGH_I,
  input wire logic SELECT_EXPAND_LOW_N_I,
  input wire logic BURST_STEP_N_I,
  input wire logic [`SSCP_LANES-1:0] BYTE_LANE_WRITE_SEL_N_I,
  input wire logic LANE_WRITE_QUALIFIER_N_I,
  input wire logic ALL_LANES_WRITE_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic [`SSCP_DATA_W-1:0] DQ_I,
  output logic [`SSCP_DATA_W-1:0] DQ_O,
  output logic DQ_OE_O
);

  // ==========================================================
  // Decoding
  function automatic sscp_lane_mask_t lane_write_mask(
    input logic all_n,
    input logic qual_n,
    input sscp_lane_mask_t sel_n
  );
    sscp_lane_mask_t m;
    m = `SSCP_LANES_NONE;
    if (!all_n) begin
      m = `SSCP_LANES_ALL;
    end else if (!qual_n) begin
      m = ~sel_n;
    end else begin
      m = `SSCP_LANES_NONE;
    end
    return m;
  endfunction

  sscp_state_e state_reg;
  sscp_addr_hi_t addr_hi_reg;
  sscp_addr_hi_t addr_hi_in;
  logic [`SSCP_BURST_W-1:0] burst_seed;
  logic [`SSCP_BURST_W-1:0] burst_count;
  logic [`SSCP_ADDR_W-1:0] access_index;
  logic third_active;
  logic sel_all;
  logic strobe_proc;
  logic strobe_ctrl;
  logic strobe_any;
  logic start_sel;
  logic start_desel;
  logic access;
  logic burst_step;
  sscp_lane_mask_t access_mask;
  logic is_read;
  logic wr_pend_reg;
  sscp_lane_mask_t wr_mask_reg;
  logic [`SSCP_ADDR_W-1:0] wr_addr_reg;
  logic [`SSCP_DATA_W-1:0] wr_data_reg;
  logic drive_ok_reg;

  assign addr_hi_in = ADDR_I[`SSCP_ADDR_W-1:`SSCP_BURST_W];
  assign burst_seed = ADDR_I[`SSCP_BURST_W-1:0];
  assign third_active = SELECT_THIRD_PRESENT ? ~SELECT_EXPAND_LOW_N_I : 1'b1;
  assign sel_all = ~SELECT_PRIMARY_N_I & SELECT_EXPAND_HIGH_I & third_active;
  assign strobe_proc = ~PROC_ADDR_STROBE_N_I & ~SELECT_PRIMARY_N_I;
  assign strobe_ctrl = ~CTRL_ADDR_STROBE_N_I & ~strobe_proc;
  assign strobe_any = strobe_proc | strobe_ctrl;
  assign start_sel = strobe_any & sel_all;
  assign start_desel = strobe_any & ~sel_all;
  assign access = (state_reg == SSCP_ACTIVE);
  assign access_mask = lane_write_mask(ALL_LANES_WRITE_N_I, LANE_WRITE_QUALIFIER_N_I,
                                       BYTE_LANE_WRITE_SEL_N_I);
  assign is_read = (access_mask == `SSCP_LANES_NONE);
  assign burst_step = access & ~start_sel & ~BURST_STEP_N_I;
  assign access_index = {addr_hi_reg, burst_count};

  // ==========================================================
  // Selection state
  // A strobe while deselected by the expansion selects ends any burst
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      state_reg <= SSCP_IDLE;
    end else if (start_sel) begin
      state_reg <= SSCP_ACTIVE;
    end else if (start_desel) begin
      state_reg <= SSCP_IDLE;
    end
  end

  // ==========================================================
  // Address capture
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      addr_hi_reg <= '0;
    end else if (start_sel) begin
      addr_hi_reg <= addr_hi_in;
    end
  end

  sscp_burst_ctr u_burst_ctr (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .load_i(start_sel),
    .step_i(burst_step),
    .seed_i(burst_seed),
    .count_o(burst_count)
  );

  // ==========================================================
  // Write capture
  // Self-timed write: the array is updated one edge after capture
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      wr_pend_reg <= 1'b0;
      wr_mask_reg <= `SSCP_LANES_NONE;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_pend_reg <= access & ~is_read;
      wr_mask_reg <= access ? access_mask : `SSCP_LANES_NONE;
      wr_addr_reg <= access_index;
      wr_data_reg <= DQ_I;
    end
  end

  // ==========================================================
  // Array and read pipeline
  // No bypass: a read right after a write to the same word sees old data
  for (genvar g = 0; g < `SSCP_LANES; g++) begin : g_lane
    logic [`SSCP_LANE_W-1:0] lane_mem [`SSCP_DEPTH];
    logic [`SSCP_LANE_W-1:0] rd_lane_reg;

    always_ff @(posedge REF_CLK_I) begin
      if (wr_pend_reg && wr_mask_reg[g]) begin
        lane_mem[wr_addr_reg] <= wr_data_reg[g*`SSCP_LANE_W +: `SSCP_LANE_W];
      end
    end

    always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
        rd_lane_reg <= '0;
      end else if (access && is_read) begin
        rd_lane_reg <= lane_mem[access_index];
      end
    end

    assign DQ_O[g*`SSCP_LANE_W +: `SSCP_LANE_W] = rd_lane_reg;
  end

  // ==========================================================
  // Output direction
  // Capture edge from idle leaves drive off, which masks enable there
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      drive_ok_reg <= 1'b0;
    end else begin
      drive_ok_reg <= access & is_read;
    end
  end

  // One gate after the flop: enable must act without the clock
  assign DQ_OE_O = drive_ok_reg & ~OUTPUT_ENABLE_N_I;

  // ==========================================================
  // Checks
  AST_ADDR_CAPTURE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    start_sel |=> addr_hi_reg == $past(addr_hi_in) && state_reg == SSCP_ACTIVE)
    else $error("address not captured on a selected strobe");

  AST_ADDR_HOLD: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !start_sel |=> $stable(addr_hi_reg))
    else $error("upper address changed without a selected strobe");

  AST_SEED_LOAD: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    start_sel |=> burst_count == $past(burst_seed))
    else $error("burst counter not seeded from low address bits");

  AST_BURST_STEP: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    access && !strobe_any && !BURST_STEP_N_I
      |=> burst_count == $past(burst_count) + `SSCP_BURST_STEP)
    else $error("burst counter did not advance");

  AST_PROC_IGNORED: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !PROC_ADDR_STROBE_N_I && SELECT_PRIMARY_N_I && CTRL_ADDR_STROBE_N_I
      |=> $stable(state_reg) && $stable(addr_hi_reg))
    else $error("processor strobe acted with first select high");

  AST_DESELECT: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    strobe_any && !SELECT_EXPAND_HIGH_I |=> state_reg == SSCP_IDLE ##1 !drive_ok_reg)
    else $error("device not deselected by inactive expansion select");

  AST_QUALIFIER_OFF: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    ALL_LANES_WRITE_N_I && LANE_WRITE_QUALIFIER_N_I |=> !wr_pend_reg)
    else $error("lane write without qualifier");

  AST_GLOBAL_WRITE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    access && !ALL_LANES_WRITE_N_I |=> wr_pend_reg && wr_mask_reg == `SSCP_LANES_ALL)
    else $error("global write did not select all lanes");

  AST_WRITE_DATA: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    access && !is_read |=> wr_data_reg == $past(DQ_I) && wr_addr_reg == $past(access_index))
    else $error("write data or address not captured");

  AST_FIRST_MASK: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !access && start_sel |=> !DQ_OE_O)
    else $error("output driven in first clock after deselect");

  AST_OE_HIGH: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    OUTPUT_ENABLE_N_I |-> !DQ_OE_O)
    else $error("data pins driven with output enable high");

  AST_READ_DRIVE: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    access && is_read && !OUTPUT_ENABLE_N_I ##1 !OUTPUT_ENABLE_N_I |-> DQ_OE_O)
    else $error("read cycle did not drive the data pins");

endmodule // sscp_top

// >>> sim/sscp_host_model.sv
// Host controller model driving the SRAM control pins
`timescale 1ns/10ps
module sscp_host_model (
  input wire logic clk_i,
  output logic proc_stb_n_o,
  output logic ctrl_stb_n_o,
  output logic sel_pri_n_o,
  output logic sel_hi_o,
  output logic sel_lo_n_o,
  output logic step_n_o,
  output logic [3:0] lane_n_o,
  output logic qual_n_o,
  output logic all_n_o,
  output logic oe_n_o,
  output logic [17:0] addr_o,
  output logic [35:0] dq_o
);
  // ==========================================================
  // Bus cycles, changed at the falling edge only
  initial begin
    {proc_stb_n_o, ctrl_stb_n_o, sel_pri_n_o, sel_hi_o, sel_lo_n_o} = 5'h1d;
    {step_n_o, qual_n_o, all_n_o, oe_n_o} = 4'hf;
    lane_n_o = 4'hf;
    addr_o = 18'h0;
    dq_o = 36'h0;
  end
  task automatic start(input logic proc, input logic [2:0] bad, input logic [17:0] a);
    {proc_stb_n_o, ctrl_stb_n_o} = {!proc, proc};
    {sel_pri_n_o, sel_hi_o, sel_lo_n_o} = {bad[0], !bad[1], bad[2]};
    {step_n_o, qual_n_o, all_n_o} = 3'h7;
    addr_o = a;
    dq_o = ~dq_o;
    @(negedge clk_i);
  endtask
  // Released data lines toggle so a stale value never passes for read data
  task automatic access(input logic step, input logic all, input logic qual,
                        input logic [3:0] lanes_n, input logic [35:0] d);
    {proc_stb_n_o, ctrl_stb_n_o} = 2'h3;
    {step_n_o, all_n_o, qual_n_o} = {!step, !all, !qual};
    lane_n_o = lanes_n;
    dq_o = (all | qual) ? d : ~dq_o;
    @(negedge clk_i);
  endtask
  task automatic set_oe(input logic on);
    oe_n_o = !on;
  endtask
endmodule // sscp_host_model

// >>> sim/sscp_top_tb.sv
// Self-checking bench for the SRAM control port
`timescale 1ns/10ps
module sscp_top_tb;
  localparam logic [17:0] BASE = 18'h2a5c0;
  logic clk;
  logic rst_n;
  logic ps_n, cs_n, pri_n, hi, lo_n, step_n, qual_n, all_n, oe_n, dq_oe, dq_oe2;
  logic [35:0] dq_rd2;
  logic [3:0] lane_n;
  logic [17:0] addr;
  logic [35:0] hdq, dq_rd, dq_bus;
  logic [35:0] mem_exp [4];
  int fail_count, compares, cyc;
  // Device drives only while enabled, otherwise the host level shows
  assign dq_bus = dq_oe ? dq_rd : hdq;
  sscp_host_model host (.clk_i(clk), .proc_stb_n_o(ps_n), .ctrl_stb_n_o(cs_n),
    .sel_pri_n_o(pri_n), .sel_hi_o(hi), .sel_lo_n_o(lo_n), .step_n_o(step_n),
    .lane_n_o(lane_n), .qual_n_o(qual_n), .all_n_o(all_n), .oe_n_o(oe_n),
    .addr_o(addr), .dq_o(hdq));
  sscp_top dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .PROC_ADDR_STROBE_N_I(ps_n), .CTRL_ADDR_STROBE_N_I(cs_n),
    .SELECT_PRIMARY_N_I(pri_n), .SELECT_EXPAND_HIGH_I(hi),
    .SELECT_EXPAND_LOW_N_I(lo_n), .BURST_STEP_N_I(step_n),
    .BYTE_LANE_WRITE_SEL_N_I(lane_n), .LANE_WRITE_QUALIFIER_N_I(qual_n),
    .ALL_LANES_WRITE_N_I(all_n), .OUTPUT_ENABLE_N_I(oe_n), .DQ_I(dq_bus),
    .DQ_O(dq_rd), .DQ_OE_O(dq_oe));
  // Variant without the third select: that pin must not deselect it
  sscp_top #(.SELECT_THIRD_PRESENT(1'b0)) dut_nothird (.REF_CLK_I(clk), .RST_N_I(rst_n),
    .ADDR_I(addr), .PROC_ADDR_STROBE_N_I(ps_n), .CTRL_ADDR_STROBE_N_I(cs_n),
    .SELECT_PRIMARY_N_I(pri_n), .SELECT_EXPAND_HIGH_I(hi),
    .SELECT_EXPAND_LOW_N_I(lo_n), .BURST_STEP_N_I(step_n),
    .BYTE_LANE_WRITE_SEL_N_I(lane_n), .LANE_WRITE_QUALIFIER_N_I(qual_n),
    .ALL_LANES_WRITE_N_I(all_n), .OUTPUT_ENABLE_N_I(oe_n), .DQ_I(dq_bus),
    .DQ_O(dq_rd2), .DQ_OE_O(dq_oe2));
  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Deselect edge still reads, so the idle edge after it is checked
  // Enable on here, else the drive check could never trip
  task automatic close_burst();
    host.set_oe(1'b1);
    host.start(1'b0, 3'h2, 18'h0);
    host.access(1'b0, 1'b0, 1'b0, 4'hf, 36'h0);
    check({35'h0, dq_oe}, 36'h0);
  endtask
  task automatic burst_write();
    host.set_oe(1'b0);
    host.start(1'b1, 3'h0, BASE);
    for (int k = 0; k < 4; k++) begin
      mem_exp[k] = 36'h9a5c31e70 + k * 36'h101010101;
      host.access(1'b1, 1'b1, k[0], 4'hf, mem_exp[k]);
    end
    close_burst();
  endtask
  task automatic read_check(input logic [1:0] seed, input int n);
    host.set_oe(1'b1);
    host.start(1'b0, 3'h0, BASE | 18'(seed));
    check({35'h0, dq_oe}, 36'h0);
    for (int k = 0; k < n; k++) begin
      host.access(1'b1, 1'b0, 1'b0, 4'hf, 36'h0);
      check(dq_rd, mem_exp[(seed + k) % 4]);
      check({35'h0, dq_oe}, 36'h1);
    end
    host.set_oe(1'b0);
    #1;
    check({35'h0, dq_oe}, 36'h0);
    @(negedge clk);
    close_burst();
  endtask
  task automatic byte_write();
    logic [35:0] z;
    z = 36'h5c3a96e1d;
    host.start(1'b1, 3'h0, BASE);
    host.access(1'b1, 1'b0, 1'b1, 4'ha, z);
    host.access(1'b1, 1'b0, 1'b0, 4'h0, ~z);
    for (int g = 0; g < 4; g += 2) begin
      mem_exp[0][9*g +: 9] = z[9*g +: 9];
    end
    close_burst();
  endtask
  // Any one select inactive, or the processor strobe under primary high
  task automatic no_select();
    host.set_oe(1'b1);
    for (int i = 0; i < 4; i++) begin
      host.start(i == 0, (i == 0) ? 3'h1 : 3'(1 << (i - 1)), BASE);
      host.access(1'b0, 1'b0, 1'b0, 4'hf, 36'h0);
      check({35'h0, dq_oe}, 36'h0);
      check({35'h0, dq_oe2}, {35'h0, i == 3});
    end
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    burst_write();
    read_check(2'h2, 4);
    byte_write();
    read_check(2'h0, 2);
    no_select();
    wrap_up();
  end
endmodule // sscp_top_tb
